// file: hw/iopfs_pkg.sv
// package of constants for the port function select block
package iopfs_pkg;
  // ----------------------------------------
  // operating modes
  // ----------------------------------------
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;
  // ----------------------------------------
  // pin positions and reset values
  // ----------------------------------------
  localparam int P4_IRQ_BIT = 0;
  localparam int P4_CLK_BIT = 6;
  localparam int P5_TX_BIT = 0;
  localparam int P5_RX_BIT = 1;
  localparam int P5_SCK_BIT = 2;
  localparam int P2_SERIAL1_CLOCK_PIN_BIT = 7;
  localparam int P2_RX1_BIT = 6;
  localparam int P2_TX1_BIT = 5;
  localparam int P2_TWOWIRE1_CLOCK_PIN_BIT = 4;
  localparam int P2_TWOWIRE1_DATA_PIN_BIT = 3;
  localparam int P2_UPPER_LO = 4;
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] OUT_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
endpackage

// file: hw/iopfs_top.sv
// port function select logic for seven ports
`timescale 1ns/10ps
// ----------------------------------------
// Summary of operation
// - bidirectional ports hold direction and output value registers; port 7 none
// - six bidirectional ports one to six, and input-only port seven
// - ports one to three have pull-up control registers per pin
// - modes 2/3 expanded: port 1 input at dir 0, address or pwm at dir 1
// - modes 2/3 expanded: port 2 dir 0 is input, serial one or blanking
// - modes 2/3 expanded: port 2 dir 1 drives upper address or top pwm
// - modes 2/3 expanded: top four port 2 pins may be ports, serial, blanking
// - single chip: port 2 general io plus pwm, serial one, blanking, two-wire
// - modes 2/3: clock pin input at dir 0, system clock out at dir 1
// - lowest port 4 pin also interrupt two and converter trigger
// - port 5 pins also serial zero transmit, receive and shared clock
// ----------------------------------------
module iopfs_top #(
  parameter int W = 8,
  parameter int P5W = 3
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // mode selection
  input wire logic [1:0] op_mode,
  input wire logic expansion_enable,
  // register write port: sel 1..6 picks port, kind 0 dir 1 value 2 pull-up
  input wire logic reg_wr,
  input wire logic [2:0] reg_sel,
  input wire logic [1:0] reg_kind,
  input wire logic [W-1:0] reg_wdata,
  // alternate function requests
  input wire logic [15:0] bus_addr,
  input wire logic [W-1:0] bus_wdata,
  input wire logic bus_drive_data,
  input wire logic [15:0] pulse_width_out,
  input wire logic pwm_sel_p1,
  input wire logic pwm_sel_p2,
  input wire logic serial1_enable,
  input wire logic serial1_transmit_pin,
  input wire logic serial1_clock_out,
  input wire logic serial1_clock_oe,
  input wire logic timer_blanking_out,
  input wire logic blanking_enable,
  input wire logic twowire1_enable,
  input wire logic twowire1_clock_low,
  input wire logic twowire1_data_low,
  input wire logic serial0_enable,
  input wire logic serial0_transmit_pin,
  input wire logic serial0_clock_out,
  input wire logic serial0_clock_oe,
  input wire logic sys_clock_tick,
  // pin inputs
  input wire logic [W-1:0] p1_in,
  input wire logic [W-1:0] p2_in,
  input wire logic [W-1:0] p3_in,
  input wire logic [W-1:0] p4_in,
  input wire logic [P5W-1:0] p5_in,
  input wire logic [W-1:0] p6_in,
  input wire logic [W-1:0] p7_in,
  // pin outputs and enables (enable low = driving)
  output logic [W-1:0] p1_out,
  output logic [W-1:0] p1_oe_n,
  output logic [W-1:0] p2_out,
  output logic [W-1:0] p2_oe_n,
  output logic [W-1:0] p3_out,
  output logic [W-1:0] p3_oe_n,
  output logic [W-1:0] p4_out,
  output logic [W-1:0] p4_oe_n,
  output logic [P5W-1:0] p5_out,
  output logic [P5W-1:0] p5_oe_n,
  output logic [W-1:0] p6_out,
  output logic [W-1:0] p6_oe_n,
  // pull-up enables for ports 1 to 3
  output logic [W-1:0] p1_pullup_on,
  output logic [W-1:0] p2_pullup_on,
  output logic [W-1:0] p3_pullup_on,
  // pin levels seen by internal modules
  output logic [W-1:0] port_read_1,
  output logic [W-1:0] port_read_2,
  output logic [W-1:0] port_read_3,
  output logic [W-1:0] port_read_4,
  output logic [P5W-1:0] port_read_5,
  output logic [W-1:0] port_read_6,
  output logic [W-1:0] port_read_7,
  output logic [W-1:0] bus_rdata,
  output logic serial1_receive_pin,
  output logic serial1_clock_pin,
  output logic serial0_receive_pin,
  output logic serial0_clock_pin,
  output logic external_clock_in,
  output logic external_interrupt_2,
  output logic converter_trigger_in
);

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [W-1:0] dir_q [1:6];
  logic [W-1:0] pin_output_value_reg_q [1:6];
  logic [W-1:0] pullup_control_reg_q [1:3];

  // decoded modes
  logic mode1;
  logic expanded;
  logic single_chip;
  assign mode1 = (op_mode == iopfs_pkg::MODE_1);
  assign expanded = ((op_mode == iopfs_pkg::MODE_2) || (op_mode == iopfs_pkg::MODE_3)) && expansion_enable;
  assign single_chip = !mode1 && !expanded;

  // one write decode used for every port and register kind
  function automatic logic hit(input logic [2:0] sel, input int idx, input logic [1:0] kind, input int k);
    hit = reg_wr && (sel == idx[2:0]) && (kind == k[1:0]);
  endfunction

  // ----------------------------------------
  // direction, value and pull-up registers
  // ----------------------------------------
  // port 7 has no slot: writes with sel 7 or 0 are ignored
  generate
    for (genvar i = 1; i <= 6; i++) begin : g_regs
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          dir_q[i] <= iopfs_pkg::DIR_RESET;
          pin_output_value_reg_q[i] <= iopfs_pkg::OUT_RESET;
        end else if (clk_en) begin
          if (hit(reg_sel, i, reg_kind, 0)) begin
            dir_q[i] <= reg_wdata;
          end
          if (hit(reg_sel, i, reg_kind, 1)) begin
            pin_output_value_reg_q[i] <= reg_wdata;
          end
        end
      end
    end
    for (genvar j = 1; j <= 3; j++) begin : g_pull
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          pullup_control_reg_q[j] <= iopfs_pkg::PULLUP_RESET;
        end else if (clk_en && hit(reg_sel, j, reg_kind, 2)) begin
          pullup_control_reg_q[j] <= reg_wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // combinational pin function select
  // ----------------------------------------
  logic [W-1:0] p1_d, p1_en, p2_d, p2_en, p3_d, p3_en, p4_d, p4_en, p6_d, p6_en;
  logic [P5W-1:0] p5_d, p5_en;

  // port 1: address low byte or pwm low outputs
  always_comb begin
    p1_d = pin_output_value_reg_q[1];
    p1_en = dir_q[1];
    if (mode1) begin
      p1_d = bus_addr[7:0];
      p1_en = '1;
    end else if (expanded) begin
      p1_d = pwm_sel_p1 ? pulse_width_out[7:0] : bus_addr[7:0];
      p1_en = dir_q[1];
    end else if (pwm_sel_p1) begin
      p1_d = pulse_width_out[7:0];
    end
  end

  // port 2: address high byte, pwm, serial one, blanking, two-wire one
  always_comb begin
    p2_d = pin_output_value_reg_q[2];
    p2_en = dir_q[2];
    if (mode1) begin
      p2_d = bus_addr[15:8];
      p2_en = '1;
    end else if (expanded) begin
      // lower four pins follow address at dir 1; upper four may be ports
      p2_d[iopfs_pkg::P2_UPPER_LO-1:0] = bus_addr[11:8];
      p2_d[W-1:iopfs_pkg::P2_UPPER_LO] = pwm_sel_p2 ? pulse_width_out[15:12] : bus_addr[15:12];
      if (!pwm_sel_p2 && !serial1_enable && !blanking_enable) begin
        p2_d[W-1:iopfs_pkg::P2_UPPER_LO] = bus_addr[15:12];
      end
      if (serial1_enable || blanking_enable) begin
        p2_d[W-1:iopfs_pkg::P2_UPPER_LO] = pin_output_value_reg_q[2][W-1:iopfs_pkg::P2_UPPER_LO];
      end
    end else begin
      if (pwm_sel_p2) begin
        p2_d = pulse_width_out[15:8];
      end
      if (twowire1_enable) begin
        p2_d[iopfs_pkg::P2_TWOWIRE1_CLOCK_PIN_BIT] = 1'b0;
        p2_d[iopfs_pkg::P2_TWOWIRE1_DATA_PIN_BIT] = 1'b0;
        p2_en[iopfs_pkg::P2_TWOWIRE1_CLOCK_PIN_BIT] = twowire1_clock_low;
        p2_en[iopfs_pkg::P2_TWOWIRE1_DATA_PIN_BIT] = twowire1_data_low;
      end
    end
    // serial one and blanking override regardless of dir in modes 2/3
    if (!mode1 && serial1_enable) begin
      p2_d[iopfs_pkg::P2_TX1_BIT] = serial1_transmit_pin;
      p2_en[iopfs_pkg::P2_TX1_BIT] = 1'b1;
      p2_en[iopfs_pkg::P2_RX1_BIT] = 1'b0;
      p2_d[iopfs_pkg::P2_SERIAL1_CLOCK_PIN_BIT] = serial1_clock_out;
      p2_en[iopfs_pkg::P2_SERIAL1_CLOCK_PIN_BIT] = serial1_clock_oe;
    end
    if (!mode1 && blanking_enable) begin
      p2_d[iopfs_pkg::P2_SERIAL1_CLOCK_PIN_BIT] = timer_blanking_out;
      p2_en[iopfs_pkg::P2_SERIAL1_CLOCK_PIN_BIT] = 1'b1;
    end
  end

  // port 3: data bus in mode 1, general io otherwise
  always_comb begin
    p3_d = pin_output_value_reg_q[3];
    p3_en = dir_q[3];
    if (mode1) begin
      p3_d = bus_wdata;
      p3_en = {W{bus_drive_data}};
    end
  end

  // port 4: clock pin, interrupt/trigger pin; port 5: serial zero
  always_comb begin
    p4_d = pin_output_value_reg_q[4];
    p4_en = dir_q[4];
    if (dir_q[4][iopfs_pkg::P4_CLK_BIT]) begin
      p4_d[iopfs_pkg::P4_CLK_BIT] = sys_clock_tick;
    end
    p5_d = pin_output_value_reg_q[5][P5W-1:0];
    p5_en = dir_q[5][P5W-1:0];
    if (serial0_enable) begin
      p5_d[iopfs_pkg::P5_TX_BIT] = serial0_transmit_pin;
      p5_en[iopfs_pkg::P5_TX_BIT] = 1'b1;
      p5_en[iopfs_pkg::P5_RX_BIT] = 1'b0;
      p5_d[iopfs_pkg::P5_SCK_BIT] = serial0_clock_out;
      p5_en[iopfs_pkg::P5_SCK_BIT] = serial0_clock_oe;
    end
    p6_d = pin_output_value_reg_q[6];
    p6_en = dir_q[6];
  end

  // ----------------------------------------
  // registered pin outputs
  // ----------------------------------------
  // registering costs one cycle of latency on every alternate function
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {p1_out, p2_out, p3_out, p4_out, p5_out, p6_out} <= '0;
      {p1_oe_n, p2_oe_n, p3_oe_n, p4_oe_n, p5_oe_n, p6_oe_n} <= '1;
    end else if (clk_en) begin
      p1_out <= p1_d;
      p1_oe_n <= ~p1_en;
      p2_out <= p2_d;
      p2_oe_n <= ~p2_en;
      p3_out <= p3_d;
      p3_oe_n <= ~p3_en;
      p4_out <= p4_d;
      p4_oe_n <= ~p4_en;
      p5_out <= p5_d;
      p5_oe_n <= ~p5_en;
      p6_out <= p6_d;
      p6_oe_n <= ~p6_en;
    end
  end

  // pull-ups only act on pins in input mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {p1_pullup_on, p2_pullup_on, p3_pullup_on} <= '0;
    end else if (clk_en) begin
      p1_pullup_on <= pullup_control_reg_q[1] & ~p1_en;
      p2_pullup_on <= pullup_control_reg_q[2] & ~p2_en;
      p3_pullup_on <= pullup_control_reg_q[3] & ~p3_en;
    end
  end

  // ----------------------------------------
  // registered pin reads and alternate inputs
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {port_read_1, port_read_2, port_read_3, port_read_4, port_read_6, port_read_7, bus_rdata} <= '0;
      port_read_5 <= '0;
      {serial1_receive_pin, serial1_clock_pin, serial0_receive_pin, serial0_clock_pin} <= 4'hf;
      {external_clock_in, external_interrupt_2, converter_trigger_in} <= 3'h7;
    end else if (clk_en) begin
      port_read_1 <= p1_in;
      port_read_2 <= p2_in;
      port_read_3 <= p3_in;
      port_read_4 <= p4_in;
      port_read_5 <= p5_in;
      port_read_6 <= p6_in;
      port_read_7 <= p7_in;
      bus_rdata <= p3_in;
      serial1_receive_pin <= p2_in[iopfs_pkg::P2_RX1_BIT];
      serial1_clock_pin <= p2_in[iopfs_pkg::P2_SERIAL1_CLOCK_PIN_BIT];
      serial0_receive_pin <= p5_in[iopfs_pkg::P5_RX_BIT];
      serial0_clock_pin <= p5_in[iopfs_pkg::P5_SCK_BIT];
      external_clock_in <= p4_in[iopfs_pkg::P4_CLK_BIT];
      external_interrupt_2 <= p4_in[iopfs_pkg::P4_IRQ_BIT];
      converter_trigger_in <= p4_in[iopfs_pkg::P4_IRQ_BIT];
    end
  end

endmodule

// file: verification/iopfs_monitor.sv
// checker of port pin selection at the top module ports
`timescale 1ns/10ps
module iopfs_monitor #(
  parameter int W = 8,
  parameter int P5W = 3
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // controls
  input wire logic [1:0] op_mode,
  input wire logic expansion_enable,
  input wire logic reg_wr,
  input wire logic [2:0] reg_sel,
  input wire logic [1:0] reg_kind,
  input wire logic [W-1:0] reg_wdata,
  input wire logic [15:0] bus_addr,
  input wire logic bus_drive_data,
  input wire logic serial0_enable,
  input wire logic serial0_transmit_pin,
  // pins
  input wire logic [W-1:0] p1_out,
  input wire logic [W-1:0] p1_oe_n,
  input wire logic [W-1:0] p2_out,
  input wire logic [W-1:0] p2_oe_n,
  input wire logic [W-1:0] p3_oe_n,
  input wire logic [W-1:0] p4_in,
  input wire logic [P5W-1:0] p5_in,
  input wire logic [P5W-1:0] p5_out,
  input wire logic [P5W-1:0] p5_oe_n,
  input wire logic [W-1:0] p7_in,
  input wire logic [W-1:0] p1_pullup_on,
  // internal views
  input wire logic [W-1:0] port_read_7,
  input wire logic serial0_receive_pin,
  input wire logic external_clock_in,
  input wire logic external_interrupt_2,
  input wire logic converter_trigger_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic en_q;
  // last edge was live; outputs are frozen or reset otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'h0;
    end else begin
      en_q <= clk_en;
    end
  end
  // ----------------------------------------
  // pin relations
  // ----------------------------------------
  AST_M1_LOW: assert property (
    en_q && $past(op_mode) == iopfs_pkg::MODE_1 |-> p1_oe_n == 8'h00 && p1_out == $past(bus_addr[7:0]))
    else $error("port 1 not on low address");
  AST_M1_HIGH: assert property (
    en_q && $past(op_mode) == iopfs_pkg::MODE_1 |-> p2_oe_n == 8'h00 && p2_out == $past(bus_addr[15:8]))
    else $error("port 2 not on high address");
  AST_M1_DATA: assert property (
    en_q && $past(op_mode) == iopfs_pkg::MODE_1 |-> p3_oe_n == {W{!$past(bus_drive_data)}})
    else $error("port 3 data direction wrong");
  AST_DIR_PINS: assert property (
    reg_wr && clk_en && reg_sel == 3'h1 && reg_kind == 2'h0 ##1 clk_en && op_mode == iopfs_pkg::MODE_2
    && !expansion_enable |=> p1_oe_n == ~$past(reg_wdata, 2)) else $error("port 1 direction not applied");
  AST_IN_ONLY: assert property (en_q |-> port_read_7 == $past(p7_in)) else $error("port 7 read wrong");
  AST_IRQ_TRIG: assert property (
    en_q |-> external_interrupt_2 == $past(p4_in[0]) && converter_trigger_in == $past(p4_in[0]))
    else $error("interrupt or trigger input wrong");
  AST_CLK_IN: assert property (en_q |-> external_clock_in == $past(p4_in[6])) else $error("clock in wrong");
  AST_SER0_RX: assert property (en_q |-> serial0_receive_pin == $past(p5_in[1])) else $error("rx0 wrong");
  AST_SER0_TX: assert property (
    en_q && $past(serial0_enable) |-> !p5_oe_n[0] && p5_out[0] == $past(serial0_transmit_pin))
    else $error("tx0 pin wrong");
  AST_PULLUP: assert property ((p1_pullup_on & ~p1_oe_n) == 8'h00) else $error("pull-up on driven pin");
  // main scenarios
  cover property (en_q && op_mode == iopfs_pkg::MODE_1);
  cover property (en_q && op_mode == iopfs_pkg::MODE_3 && expansion_enable);
  cover property (reg_wr && clk_en && reg_kind == 2'h2);
endmodule
bind iopfs_top iopfs_monitor #(.W(W), .P5W(P5W)) iopfs_monitor_inst (.*);

// file: verification/iopfs_pin_model.sv
// board side of a group of pins
`timescale 1ns/10ps
module iopfs_pin_model #(
  parameter int W = 8
) (
  // clock
  input wire logic clk,
  // drive from the port
  input wire logic [W-1:0] drv,
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] pu,
  // level on the wire
  output logic [W-1:0] lvl
);
  logic [W-1:0] pat = '0;
  // floating lines flip each cycle so stale data never looks valid
  always @(posedge clk) begin
    pat <= ~pat;
  end
  assign lvl = (drv & ~oe_n) | (oe_n & pu) | (oe_n & ~pu & pat);
endmodule

// file: verification/tb_io_port_function_select.sv
// testbench of the port function select block
`timescale 1ns/10ps
module tb_io_port_function_select;
  typedef struct packed {
    logic [1:0] m;
    logic x;
    logic p;
    logic [7:0] d, o1, e1, o2, e2;
  } iopfs_row_t;
  logic clk, clk_en = 1'h1, rst_n = 1'h0, reg_wr = 1'h0, expansion_enable = 1'h0, pwm_sel = 1'h0;
  logic [1:0] op_mode = iopfs_pkg::MODE_2, reg_kind = 2'h0;
  logic [2:0] reg_sel = 3'h0;
  logic [7:0] reg_wdata = 8'h00, cnt = 8'h00;
  logic [15:0] bus_addr = 16'ha5c3;
  logic serial1_enable = 1'h0, blanking_enable = 1'h0, twowire1_enable = 1'h0, serial0_enable = 1'h1;
  logic [15:0] pulse_width_out = 16'h3c96;
  logic [7:0] p1_out, p1_oe_n, p2_out, p2_oe_n, p3_out, p3_oe_n, p4_out, p4_oe_n, p6_out, p6_oe_n;
  logic [7:0] p1_in, p2_in, p3_in, p4_in, p6_in, p7_in, p1_pullup_on, p2_pullup_on, p3_pullup_on, bus_rdata;
  logic [7:0] port_read_1, port_read_2, port_read_3, port_read_4, port_read_6, port_read_7;
  logic [2:0] p5_out, p5_oe_n, p5_in, port_read_5;
  logic serial1_receive_pin, serial1_clock_pin, serial0_receive_pin, serial0_clock_pin;
  logic external_clock_in, external_interrupt_2, converter_trigger_in;
  int error_cnt = 0, total_checks = 0;
  // side inputs wander with a counter
  wire logic [7:0] bus_wdata = cnt;
  wire logic bus_drive_data = cnt[2];
  wire logic serial1_transmit_pin = cnt[0];
  wire logic serial1_clock_out = cnt[1];
  wire logic serial1_clock_oe = cnt[2];
  wire logic timer_blanking_out = cnt[3];
  wire logic twowire1_clock_low = cnt[4];
  wire logic twowire1_data_low = cnt[5];
  wire logic serial0_transmit_pin = cnt[6];
  wire logic serial0_clock_out = cnt[7];
  wire logic serial0_clock_oe = cnt[1];
  wire logic sys_clock_tick = cnt[0];
  // counter value that the pins registered at the last edge
  wire logic [7:0] cnt_prev = cnt - 8'h01;
  iopfs_row_t rows [6] = '{
    '{iopfs_pkg::MODE_2, 1'h0, 1'h0, 8'h0f, 8'h5a, 8'hf0, 8'h5a, 8'hf0},
    '{iopfs_pkg::MODE_2, 1'h1, 1'h0, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff},
    '{iopfs_pkg::MODE_3, 1'h1, 1'h0, 8'hff, 8'hc3, 8'h00, 8'ha5, 8'h00},
    '{iopfs_pkg::MODE_3, 1'h1, 1'h1, 8'hff, 8'h96, 8'h00, 8'h35, 8'h00},
    '{iopfs_pkg::MODE_2, 1'h0, 1'h1, 8'hff, 8'h96, 8'h00, 8'h3c, 8'h00},
    '{iopfs_pkg::MODE_1, 1'h0, 1'h0, 8'h00, 8'hc3, 8'h00, 8'ha5, 8'h00}};
  iopfs_top iopfs_top_inst (.*, .pwm_sel_p1(pwm_sel), .pwm_sel_p2(pwm_sel));
  iopfs_pin_model #(.W(24)) iopfs_pin_model_inst_a (.clk(clk), .drv({p3_out, p2_out, p1_out}),
    .oe_n({p3_oe_n, p2_oe_n, p1_oe_n}), .pu({p3_pullup_on, p2_pullup_on, p1_pullup_on}), .lvl({p3_in, p2_in, p1_in}));
  iopfs_pin_model #(.W(16)) iopfs_pin_model_inst_b (.clk(clk), .drv({p6_out, p4_out}),
    .oe_n({p6_oe_n, p4_oe_n}), .pu(16'h0000), .lvl({p6_in, p4_in}));
  iopfs_pin_model #(.W(11)) iopfs_pin_model_inst_c (.clk(clk), .drv({p5_out, 8'h00}),
    .oe_n({p5_oe_n, 8'hff}), .pu(11'h000), .lvl({p5_in, p7_in}));
  // clock and side counter
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cnt <= cnt + 8'h01;
  end
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [1:0] k, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_sel <= s;
    reg_kind <= k;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask
  // pins lag the register by one edge
  task automatic settle;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog well past the hundred or so cycles of the run
  initial begin
    #20000;
    error_cnt++;
    summarize();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    @(posedge clk);
    #1;
    chk("reset oe_n", 8'hff, p1_oe_n & p2_oe_n & p3_oe_n);
    chk("reset pull-up", 8'h00, p1_pullup_on | p2_pullup_on | p3_pullup_on);
    chk("reset inputs", 8'h07, {5'h00, serial0_receive_pin, external_interrupt_2, external_clock_in});
    @(posedge clk);
    rst_n <= 1'h1;
    $display("reset test done");
    wr(3'h1, 2'h1, 8'h5a);
    wr(3'h2, 2'h1, 8'h5a);
    foreach (rows[i]) begin
      @(posedge clk);
      op_mode <= rows[i].m;
      expansion_enable <= rows[i].x;
      pwm_sel <= rows[i].p;
      wr(3'h1, 2'h0, rows[i].d);
      wr(3'h2, 2'h0, rows[i].d);
      settle();
      chk("p1 out", rows[i].o1 & ~rows[i].e1, p1_out & ~p1_oe_n);
      chk("p1 oe_n", rows[i].e1, p1_oe_n);
      chk("p2 out", rows[i].o2 & ~rows[i].e2, p2_out & ~p2_oe_n);
      chk("p2 oe_n", rows[i].e2, p2_oe_n);
      $display("row %0d done", i);
    end
    // pull-up, ignored selects and a write while frozen
    @(posedge clk);
    op_mode <= iopfs_pkg::MODE_2;
    wr(3'h3, 2'h2, 8'hff);
    wr(3'h3, 2'h0, 8'h0f);
    wr(3'h1, 2'h0, 8'h3c);
    wr(3'h0, 2'h0, 8'hff);
    wr(3'h7, 2'h0, 8'hff);
    wr(3'h1, 2'h3, 8'hff);
    clk_en <= 1'h0;
    wr(3'h1, 2'h0, 8'hff);
    clk_en <= 1'h1;
    settle();
    chk("p3 pull-up", 8'hf0, p3_pullup_on);
    chk("p1 after refused writes", 8'hc3, p1_oe_n);
    chk("p3 read", 8'hf0, port_read_3);
    chk("bus read", 8'hf0, bus_rdata);
    $display("refusal test done");
    // clock pin turns from input to clock output
    @(posedge clk);
    op_mode <= iopfs_pkg::MODE_3;
    expansion_enable <= 1'h1;
    settle();
    chk("clock pin input", 8'h01, {7'h00, p4_oe_n[6]});
    wr(3'h4, 2'h0, 8'h40);
    settle();
    chk("clock pin drive", 8'h00, {7'h00, p4_oe_n[6]});
    chk("clock pin value", {7'h00, ~cnt[0]}, {7'h00, p4_out[6]});
    $display("clock pin test done");
    // serial one, blanking and serial zero in expanded mode
    @(posedge clk);
    serial1_enable <= 1'h1;
    wr(3'h2, 2'h0, 8'hff);
    settle();
    chk("p2 serial oe_n", 8'h40, p2_oe_n & 8'h7f);
    chk("p2 port nibble", 8'h15, p2_out & 8'h1f);
    chk("tx1 pin", {7'h00, cnt_prev[0]}, {7'h00, p2_out[5]});
    chk("rx1 pin", {7'h00, ~p2_in[6]}, {7'h00, serial1_receive_pin});
    chk("p5 serial oe_n", 8'h02, {6'h00, p5_oe_n[1:0]});
    @(posedge clk);
    blanking_enable <= 1'h1;
    settle();
    chk("p2 blanking oe_n", 8'h40, p2_oe_n);
    chk("blanking pin", {7'h00, cnt_prev[3]}, {7'h00, p2_out[7]});
    $display("serial one test done");
    // two-wire lines in single-chip mode only ever pull low
    @(posedge clk);
    op_mode <= iopfs_pkg::MODE_2;
    expansion_enable <= 1'h0;
    serial1_enable <= 1'h0;
    blanking_enable <= 1'h0;
    twowire1_enable <= 1'h1;
    serial0_enable <= 1'h0;
    settle();
    chk("two-wire out", 8'h42, p2_out);
    chk("two-wire oe_n", {3'h0, ~cnt_prev[4], ~cnt_prev[5], 3'h0}, p2_oe_n);
    chk("p5 idle oe_n", 8'h07, {5'h00, p5_oe_n});
    $display("two-wire test done");
    // reset in mid-run clears every register
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk);
    rst_n <= 1'h1;
    settle();
    chk("p1 oe_n after reset", 8'hff, p1_oe_n);
    chk("p3 pull-up after reset", 8'h00, p3_pullup_on);
    chk("p2 out after reset", 8'h00, p2_out);
    $display("mid-run reset test done");
    summarize();
  end
endmodule
